// ==== dimmer_level_command_logic_test.sv ====
// self-checking bench for the dimmer level command logic
`timescale 1ns/1ps
module dimmer_level_command_logic_test;
  localparam int MSC = 2;
  localparam int WIN = 1000 * MSC + 50;
  localparam logic [7:0] RA [6] = '{8'h00, 8'h04, 8'h08, 8'h1C, 8'h20, 8'h24};
  localparam logic [31:0] RV [6] = '{32'h35, 32'h4DFF, 32'hFF_0101, 32'h7D0, 32'h0, 32'h0};
  // values, limits, zero fades (one step a cycle), control last
  localparam logic [7:0] WA [8] = '{8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h00};
  localparam logic [31:0] WV [8] = '{32'h2040_60FF, 32'hE0_1820, 32'hC0_0810, 32'h0, 32'h0,
    32'h0, 32'h0, 32'h1079};
  localparam logic [7:0] RGBX [5] = '{8'h50, 8'hA0, 8'h30, 8'h30, 8'hA0};
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, sw_valid, sw_value, dn_valid, dn_value, rel_valid, abs_valid, rgb_valid;
  logic night_mode;
  logic err;
  logic [3:0] rel_code;
  logic [7:0] abs_value, dim_level;
  logic [23:0] rgb_value;
  int n_fail = 0;
  int checked = 0;

  always #4 pclk = ~pclk;

  dlc_top #(.MS_CYCLES(MSC)) DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sw_valid(sw_valid), .sw_value(sw_value), .dn_valid(dn_valid), .dn_value(dn_value),
    .rel_valid(rel_valid), .rel_code(rel_code), .abs_valid(abs_valid),
    .abs_value(abs_value), .rgb_valid(rgb_valid), .rgb_value(rgb_value),
    .dim_level(dim_level), .night_mode(night_mode));
  dlc_bus_model bus (
    .pclk(pclk), .sw_valid(sw_valid), .sw_value(sw_value), .dn_valid(dn_valid),
    .dn_value(dn_value), .rel_valid(rel_valid), .rel_code(rel_code), .abs_valid(abs_valid),
    .abs_value(abs_value), .rgb_valid(rgb_valid), .rgb_value(rgb_value));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    if (n_fail == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk("pready", 32'h1, {31'h0, pready});
    if (pready !== 1'b1) tally_and_finish();
  endtask : apb

  task automatic lvl(input string what, input logic [7:0] exp);
    chk(what, {24'h0, exp}, {24'h0, dim_level});
  endtask : lvl

  task automatic jump(input string what, input logic [7:0] exp);
    @(negedge pclk);
    lvl(what, exp);
  endtask : jump

  // bounded wait for a ramp to settle
  task automatic settle(input string what, input logic [7:0] exp);
    int n;
    n = 0;
    while (dim_level !== exp && n < 600) begin
      @(negedge pclk);
      n++;
    end
    lvl(what, exp);
    if (n >= 600) tally_and_finish();
  endtask : settle

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, RA[i], 32'h0);
      chk("register read", RV[i], rd);
      chk("pslverr", {31'h0, i == 5}, {31'h0, err});
    end
    for (int i = 0; i < 8; i++) apb(1'b1, WA[i], WV[i]);
  endtask : t_regs

  task automatic t_off_low();
    bus.send(3, 24'h30);
    jump("abs jump", 8'h10);
    settle("abs ramp", 8'h30);
    bus.send(0, 24'h0);
    jump("low off", 8'h00);
  endtask : t_off_low

  task automatic t_onoff();
    apb(1'b1, 8'h00, 32'h1078);
    bus.send(0, 24'h1);
    jump("on ignored", 8'h00);
    apb(1'b1, 8'h00, 32'h107A);
    bus.send(0, 24'h1);
    settle("on last", 8'h30);
    apb(1'b1, 8'h00, 32'h1079);
    bus.send(0, 24'h1);
    settle("on higher", 8'hFF);
    repeat (WIN) @(posedge pclk);
    bus.send(0, 24'h0);
    settle("off fade", 8'h40);
    bus.send(0, 24'h0);
    jump("second off", 8'h00);
    bus.send(0, 24'h1);
    settle("on fix", 8'hFF);
  endtask : t_onoff

  task automatic t_daynight();
    bus.send(1, 24'h0);
    @(negedge pclk);
    chk("night", 32'h1, {31'h0, night_mode});
    settle("night on", 8'h60);
    bus.send(1, 24'h1);
    settle("day on", 8'hFF);
    apb(1'b1, 8'h00, 32'h10B9);
    bus.send(1, 24'h0);
    repeat (20) @(negedge pclk);
    lvl("deferred", 8'hFF);
    repeat (WIN) @(posedge pclk);
    bus.send(0, 24'h0);
    settle("night off", 8'h20);
    bus.send(1, 24'h1);
    @(negedge pclk);
    chk("day", 32'h0, {31'h0, night_mode});
  endtask : t_daynight

  task automatic t_abs();
    apb(1'b1, 8'h00, 32'h1079);
    bus.send(3, 24'hF0);
    settle("abs max", 8'hC0);
    bus.send(3, 24'h04);
    settle("below off", 8'h00);
    apb(1'b1, 8'h00, 32'h2079);
    bus.send(3, 24'h30);
    settle("abs set", 8'h30);
    bus.send(3, 24'h04);
    settle("zero mode clamp", 8'h08);
    bus.send(3, 24'h00);
    settle("zero mode off", 8'h00);
    apb(1'b1, 8'h00, 32'h0079);
    bus.send(3, 24'h04);
    settle("clamp mode", 8'h08);
  endtask : t_abs

  task automatic t_rgb();
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, 8'h00, 32'h1079 | (32'(i) << 8));
      bus.send(4, 24'h50A030);
      settle("colour", RGBX[i]);
    end
  endtask : t_rgb

  task automatic t_rel();
    logic [7:0] hold;
    bus.send(3, 24'h00);
    settle("abs off", 8'h00);
    bus.send(2, 24'h9);
    jump("rel jump", 8'h20);
    settle("rel max", 8'hE0);
    bus.send(2, 24'h1);
    settle("rel min", 8'h18);
    bus.send(3, 24'h10);
    settle("abs low", 8'h10);
    bus.send(2, 24'h1);
    repeat (20) @(negedge pclk);
    lvl("darker ignored", 8'h10);
    // brighter 255 ms sweep: one step per ms tick, darker stays at one step a cycle
    apb(1'b1, 8'h14, 32'h0000_00FF);
    bus.send(2, 24'h9);
    jump("rel rejump", 8'h20);
    repeat (40) @(negedge pclk);
    chk("paced ramp", 32'h1, {31'h0, dim_level > 8'h2F && dim_level < 8'h39});
    bus.send(2, 24'h8);
    @(negedge pclk);
    hold = dim_level;
    repeat (20) @(negedge pclk);
    lvl("rel stop", hold);
    bus.send(2, 24'h1);
    repeat (40) @(negedge pclk);
    lvl("darker fast", 8'h18);
  endtask : t_rel

  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_off_low();
    t_onoff();
    t_daynight();
    t_abs();
    t_rgb();
    t_rel();
    tally_and_finish();
  end
endmodule : dimmer_level_command_logic_test

// ==== dlc_bus_model.sv ====
// telegram source standing in for the building bus
`timescale 1ns/1ps
module dlc_bus_model (
  // clock
  input wire logic pclk,
  // telegram lines
  output logic sw_valid,
  output logic sw_value,
  output logic dn_valid,
  output logic dn_value,
  output logic rel_valid,
  output logic [3:0] rel_code,
  output logic abs_valid,
  output logic [7:0] abs_value,
  output logic rgb_valid,
  output logic [23:0] rgb_value
);
  initial begin
    {sw_valid, dn_valid, rel_valid, abs_valid, rgb_valid} = 5'h00;
    {sw_value, dn_value, rel_code, abs_value, rgb_value} = 38'h0;
  end
  // kind 0 switch, 1 day/night, 2 relative, 3 absolute, 4 colour
  task automatic send(input int kind, input logic [23:0] data);
    @(posedge pclk);
    sw_value <= data[0];
    dn_value <= data[0];
    rel_code <= data[3:0];
    abs_value <= data[7:0];
    rgb_value <= data;
    {sw_valid, dn_valid, rel_valid, abs_valid, rgb_valid} <= 5'h10 >> kind;
    @(posedge pclk);
    {sw_valid, dn_valid, rel_valid, abs_valid, rgb_valid} <= 5'h00;
    // idle lines carry junk so stale data is never mistaken for a telegram
    {sw_value, dn_value, rel_code, abs_value, rgb_value} <=
      ~{data[0], data[0], data[3:0], data[7:0], data};
  endtask : send
endmodule : dlc_bus_model

// ==== dlc_pkg.sv ====
// constants shared by the dimmer level command logic
package dlc_pkg;
  // clock and timing
  localparam int CLK_HZ = 125_000_000;
  localparam int CYC_PER_MS = CLK_HZ / 1000;
  localparam int OFF2_WINDOW_S = 1;
  localparam int OFF2_WINDOW_MS = OFF2_WINDOW_S * 1000;
  localparam logic [8:0] STEP_PER_MS = 9'h0FF;
  // register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_ONOFF_VAL = 8'h04;
  localparam logic [7:0] ADDR_REL_LIM = 8'h08;
  localparam logic [7:0] ADDR_ABS_LIM = 8'h0C;
  localparam logic [7:0] ADDR_FADE_ONOFF = 8'h10;
  localparam logic [7:0] ADDR_FADE_REL = 8'h14;
  localparam logic [7:0] ADDR_FADE_ABS = 8'h18;
  localparam logic [7:0] ADDR_FADE_DN = 8'h1C;
  localparam logic [7:0] ADDR_STATUS = 8'h20;
  // control field positions
  localparam int CTRL_ONOFF_LSB = 0;
  localparam int CTRL_ONON_LSB = 2;
  localparam int CTRL_OFF_BIT = 4;
  localparam int CTRL_OFF2_BIT = 5;
  localparam int CTRL_DNP_LSB = 6;
  localparam int CTRL_RGB_LSB = 8;
  localparam int CTRL_ABSM_LSB = 12;
  localparam int CTRL_W = 14;
  // reaction, day/night policy, absolute mode and colour select codes
  localparam logic [1:0] REACT_NONE = 2'h0;
  localparam logic [1:0] REACT_FIX = 2'h1;
  localparam logic [1:0] REACT_LAST = 2'h2;
  localparam logic [1:0] REACT_HIGHER = 2'h2;
  localparam logic [1:0] DNP_OFF = 2'h0;
  localparam logic [1:0] DNP_NOW = 2'h1;
  localparam logic [1:0] DNP_NEXT = 2'h2;
  localparam logic [1:0] ABS_CLAMP = 2'h0;
  localparam logic [1:0] ABS_BELOW = 2'h1;
  localparam logic [1:0] ABS_ZERO = 2'h2;
  localparam logic [2:0] RGB_FIRST = 3'h0;
  localparam logic [2:0] RGB_SECOND = 3'h1;
  localparam logic [2:0] RGB_THIRD = 3'h2;
  localparam logic [2:0] RGB_MIN = 3'h3;
  localparam logic [2:0] RGB_MAX = 3'h4;
  // reset values
  localparam logic [13:0] CTRL_RST = 14'h0035;
  localparam logic [31:0] ONOFF_VAL_RST = 32'h0000_4DFF;
  localparam logic [23:0] REL_LIM_RST = 24'hFF_0101;
  localparam logic [23:0] ABS_LIM_RST = 24'hFF_0101;
  localparam logic [31:0] FADE_RST = 32'h01F4_01F4;
  localparam logic [15:0] FADE_DN_RST = 16'h07D0;
endpackage : dlc_pkg

// ==== dlc_ramp.sv ====
// fade step pacer: 255 steps per configured full sweep time
`timescale 1ns/1ps
module dlc_ramp (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // pacing
  input wire logic ms_tick,
  input wire logic run,
  input wire logic restart,
  input wire logic [15:0] fade_ms,
  output logic step
);
  logic [17:0] acc;

  // zero fade time steps every cycle
  assign step = run && !restart && (acc >= {2'h0, fade_ms});

  // no divider: add 255 per ms, spend fade_ms per step
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc <= 18'h00000;
    end else if (!run || restart) begin
      acc <= 18'h00000;
    end else begin
      acc <= acc + (ms_tick ? {9'h000, dlc_pkg::STEP_PER_MS} : 18'h00000)
                 - (step ? {2'h0, fade_ms} : 18'h00000);
    end
  end
endmodule : dlc_ramp

// ==== dlc_rgb_pick.sv ====
// brightness byte taken from a colour value
`timescale 1ns/1ps
module dlc_rgb_pick (
  // colour in
  input wire logic [23:0] rgb,
  input wire logic [2:0] sel,
  // brightness out
  output logic [7:0] val
);
  logic [7:0] r;
  logic [7:0] g;
  logic [7:0] b;
  logic [7:0] lo;
  logic [7:0] hi;

  assign r = rgb[23:16];
  assign g = rgb[15:8];
  assign b = rgb[7:0];

  always_comb begin
    lo = (r < g) ? r : g;
    lo = (b < lo) ? b : lo;
    hi = (r > g) ? r : g;
    hi = (b > hi) ? b : hi;
    unique case (sel)
      dlc_pkg::RGB_FIRST: val = r;
      dlc_pkg::RGB_SECOND: val = g;
      dlc_pkg::RGB_THIRD: val = b;
      dlc_pkg::RGB_MIN: val = lo;
      dlc_pkg::RGB_MAX: val = hi;
      default: val = r;
    endcase
  end
endmodule : dlc_rgb_pick

// ==== dlc_top.sv ====
// dimmer level command interpreter with APB configuration
`timescale 1ns/1ps
module dlc_top #(
  parameter int MS_CYCLES = dlc_pkg::CYC_PER_MS
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // switch telegram
  input wire logic sw_valid,
  input wire logic sw_value,
  // day/night telegram
  input wire logic dn_valid,
  input wire logic dn_value,
  // relative dimming telegram
  input wire logic rel_valid,
  input wire logic [3:0] rel_code,
  // absolute value telegram
  input wire logic abs_valid,
  input wire logic [7:0] abs_value,
  // colour telegram
  input wire logic rgb_valid,
  input wire logic [23:0] rgb_value,
  // output stage
  output logic [7:0] dim_level,
  output logic night_mode
);
  ////////////////////////////////////////////////////////////////////////////////
  // configuration registers
  logic [13:0] ctrl;
  logic [31:0] onoff_val;
  logic [23:0] rel_lim;
  logic [23:0] abs_lim;
  logic [31:0] fade_onoff;
  logic [31:0] fade_rel;
  logic [31:0] fade_abs;
  logic [15:0] fade_dn;
  // channel state
  logic [7:0] target;
  logic [7:0] last_level;
  logic [15:0] fade_ms;
  logic cmd_on;
  logic [9:0] win_cnt;
  logic [16:0] ms_cnt;
  logic ms_tick;
  logic step;
  logic [7:0] rgb_bright;
  // next values
  logic [7:0] next_level;
  logic [7:0] next_target;
  logic [7:0] next_last;
  logic [15:0] next_fade;
  logic next_cmd_on;
  logic next_night;
  logic restart;
  logic off_arm;

  logic apb_access;
  logic addr_ok;
  logic [1:0] onoff_react;
  logic [1:0] onon_react;
  logic off_fix;
  logic off2_en;
  logic [1:0] dn_policy;
  logic [1:0] abs_mode;
  logic use_night;
  logic [7:0] on_val;
  logic [7:0] off_val;

  assign onoff_react = ctrl[dlc_pkg::CTRL_ONOFF_LSB +: 2];
  assign onon_react = ctrl[dlc_pkg::CTRL_ONON_LSB +: 2];
  assign off_fix = ctrl[dlc_pkg::CTRL_OFF_BIT];
  assign off2_en = ctrl[dlc_pkg::CTRL_OFF2_BIT];
  assign dn_policy = ctrl[dlc_pkg::CTRL_DNP_LSB +: 2];
  assign abs_mode = ctrl[dlc_pkg::CTRL_ABSM_LSB +: 2];
  assign use_night = night_mode && (dn_policy != dlc_pkg::DNP_OFF);
  assign on_val = use_night ? onoff_val[15:8] : onoff_val[7:0];
  assign off_val = use_night ? onoff_val[31:24] : onoff_val[23:16];

  ////////////////////////////////////////////////////////////////////////////////
  // apb slave, zero wait states
  assign apb_access = psel && penable;
  assign pready = 1'b1;

  always_comb begin
    unique case (paddr)
      dlc_pkg::ADDR_CTRL, dlc_pkg::ADDR_ONOFF_VAL, dlc_pkg::ADDR_REL_LIM,
      dlc_pkg::ADDR_ABS_LIM, dlc_pkg::ADDR_FADE_ONOFF, dlc_pkg::ADDR_FADE_REL,
      dlc_pkg::ADDR_FADE_ABS, dlc_pkg::ADDR_FADE_DN, dlc_pkg::ADDR_STATUS: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end

  assign pslverr = apb_access && !addr_ok;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= dlc_pkg::CTRL_RST;
      onoff_val <= dlc_pkg::ONOFF_VAL_RST;
      rel_lim <= dlc_pkg::REL_LIM_RST;
      abs_lim <= dlc_pkg::ABS_LIM_RST;
      fade_onoff <= dlc_pkg::FADE_RST;
      fade_rel <= dlc_pkg::FADE_RST;
      fade_abs <= dlc_pkg::FADE_RST;
      fade_dn <= dlc_pkg::FADE_DN_RST;
    end else if (apb_access && pwrite) begin
      unique case (paddr)
        dlc_pkg::ADDR_CTRL: ctrl <= pwdata[13:0];
        dlc_pkg::ADDR_ONOFF_VAL: onoff_val <= pwdata;
        dlc_pkg::ADDR_REL_LIM: rel_lim <= pwdata[23:0];
        dlc_pkg::ADDR_ABS_LIM: abs_lim <= pwdata[23:0];
        dlc_pkg::ADDR_FADE_ONOFF: fade_onoff <= pwdata;
        dlc_pkg::ADDR_FADE_REL: fade_rel <= pwdata;
        dlc_pkg::ADDR_FADE_ABS: fade_abs <= pwdata;
        dlc_pkg::ADDR_FADE_DN: fade_dn <= pwdata[15:0];
        default: ;
      endcase
    end
  end

  // read data latched in the setup cycle, stable through the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      unique case (paddr)
        dlc_pkg::ADDR_CTRL: prdata <= {18'h00000, ctrl};
        dlc_pkg::ADDR_ONOFF_VAL: prdata <= onoff_val;
        dlc_pkg::ADDR_REL_LIM: prdata <= {8'h00, rel_lim};
        dlc_pkg::ADDR_ABS_LIM: prdata <= {8'h00, abs_lim};
        dlc_pkg::ADDR_FADE_ONOFF: prdata <= fade_onoff;
        dlc_pkg::ADDR_FADE_REL: prdata <= fade_rel;
        dlc_pkg::ADDR_FADE_ABS: prdata <= fade_abs;
        dlc_pkg::ADDR_FADE_DN: prdata <= {16'h0000, fade_dn};
        dlc_pkg::ADDR_STATUS: prdata <= {13'h0000, (dim_level != target), night_mode,
                                         (dim_level != 8'h00), target, dim_level};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // millisecond tick and second-OFF window
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ms_cnt <= 17'h00000;
      ms_tick <= 1'b0;
    end else begin
      ms_tick <= (ms_cnt == 17'(MS_CYCLES - 1));
      ms_cnt <= (ms_cnt == 17'(MS_CYCLES - 1)) ? 17'h00000 : ms_cnt + 17'h00001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      win_cnt <= 10'h000;
    end else if (off_arm) begin
      win_cnt <= 10'(dlc_pkg::OFF2_WINDOW_MS);
    end else if (ms_tick && win_cnt != 10'h000) begin
      win_cnt <= win_cnt - 10'h001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // helpers
  dlc_ramp u_ramp (
    .pclk(pclk),
    .presetn(presetn),
    .ms_tick(ms_tick),
    .run(dim_level != target),
    .restart(restart),
    .fade_ms(fade_ms),
    .step(step)
  );

  dlc_rgb_pick u_rgb (
    .rgb(rgb_value),
    .sel(ctrl[dlc_pkg::CTRL_RGB_LSB +: 3]),
    .val(rgb_bright)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // command interpreter; one command per cycle, switch first, colour last
  always_comb begin
    logic [7:0] v;
    logic [7:0] lvl;
    logic [7:0] amin_on;
    logic [7:0] amin_off;
    logic [7:0] amax;
    logic off_req;
    logic nn;
    v = 8'h00;
    lvl = dim_level;
    amin_on = abs_lim[7:0];
    amin_off = abs_lim[15:8];
    amax = abs_lim[23:16];
    off_req = 1'b0;
    nn = night_mode;
    next_level = dim_level;
    next_target = target;
    next_last = last_level;
    next_fade = fade_ms;
    next_cmd_on = cmd_on;
    next_night = night_mode;
    restart = 1'b0;
    off_arm = 1'b0;
    if (sw_valid) begin
      restart = 1'b1;
      next_cmd_on = sw_value;
      if (sw_value) begin
        next_fade = fade_onoff[15:0];
        if (dim_level == 8'h00) begin
          if (onoff_react == dlc_pkg::REACT_FIX) begin
            next_target = on_val;
          end else if (onoff_react == dlc_pkg::REACT_LAST) begin
            next_target = (last_level != 8'h00) ? last_level : on_val;
          end
        end else begin
          if (onon_react == dlc_pkg::REACT_FIX) begin
            next_target = on_val;
          end else if (onon_react == dlc_pkg::REACT_HIGHER && on_val > dim_level) begin
            next_target = on_val;
          end
        end
      end else if (off2_en && win_cnt != 10'h000) begin
        next_level = 8'h00;
        next_target = 8'h00;
      end else begin
        off_arm = 1'b1;
        if (dim_level != 8'h00) begin
          next_last = dim_level;
        end
        if (off_fix) begin
          next_fade = fade_onoff[31:16];
          if (dim_level <= off_val) begin
            next_level = 8'h00;
            next_target = 8'h00;
          end else begin
            next_target = off_val;
          end
        end
      end
    end else if (dn_valid) begin
      nn = !dn_value;
      next_night = nn;
      if (dn_policy == dlc_pkg::DNP_NOW && nn != night_mode) begin
        restart = 1'b1;
        next_fade = fade_dn;
        if (cmd_on) begin
          next_target = nn ? onoff_val[15:8] : onoff_val[7:0];
        end else begin
          next_target = nn ? onoff_val[31:24] : onoff_val[23:16];
        end
      end
    end else if (rel_valid) begin
      restart = 1'b1;
      if (rel_code[2:0] == 3'h0) begin
        next_target = dim_level;
      end else if (rel_code[3]) begin
        if (dim_level <= rel_lim[23:16]) begin
          if (dim_level < rel_lim[15:8]) begin
            lvl = rel_lim[7:0];
          end
          next_level = lvl;
          next_target = rel_lim[23:16];
          next_fade = fade_rel[15:0];
        end
      end else if (dim_level >= rel_lim[15:8]) begin
        next_target = rel_lim[15:8];
        next_fade = fade_rel[31:16];
      end
    end else if (abs_valid || rgb_valid) begin
      restart = 1'b1;
      v = abs_valid ? abs_value : rgb_bright;
      if (v > amax) begin
        v = amax;
      end
      if (amin_off == 8'h00) begin
        off_req = (v == 8'h00);
      end else begin
        off_req = (v < amin_off) && ((abs_mode == dlc_pkg::ABS_BELOW) ||
                  (abs_mode == dlc_pkg::ABS_ZERO && v == 8'h00));
      end
      if (off_req) begin
        v = 8'h00;
      end else if (v < amin_off) begin
        v = amin_off;
      end
      if (v != 8'h00 && dim_level < amin_off) begin
        lvl = amin_on;
      end
      next_level = lvl;
      next_target = v;
      next_fade = (v >= lvl) ? fade_abs[15:0] : fade_abs[31:16];
    end else if (step && dim_level != target) begin
      next_level = (target > dim_level) ? dim_level + 8'h01 : dim_level - 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // channel state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dim_level <= 8'h00;
      target <= 8'h00;
      fade_ms <= 16'h0000;
    end else begin
      dim_level <= next_level;
      target <= next_target;
      fade_ms <= next_fade;
    end
  end

  // restart lands in day mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      night_mode <= 1'b0;
      cmd_on <= 1'b0;
      last_level <= 8'h00;
    end else begin
      night_mode <= next_night;
      cmd_on <= next_cmd_on;
      last_level <= next_last;
    end
  end
endmodule : dlc_top

// ==== dlc_top_asserts.sv ====
// port-level assertion checker for the dimmer level command logic
`timescale 1ns/1ps
module dlc_top_asserts (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // telegrams
  input wire logic sw_valid,
  input wire logic dn_valid,
  input wire logic dn_value,
  input wire logic rel_valid,
  input wire logic abs_valid,
  input wire logic rgb_valid,
  // output stage
  input wire logic [7:0] dim_level,
  input wire logic night_mode
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic unmapped;
  logic tg;
  assign unmapped = paddr > dlc_pkg::ADDR_STATUS || paddr[1:0] != 2'h0;
  assign tg = sw_valid || dn_valid || rel_valid || abs_valid || rgb_valid;
  ////////////////////////////////////////////////////////////////////////////////
  pready_high_a: assert property (pready)
    else $error("pready low");
  slverr_map_a: assert property (pslverr == (psel && penable && unmapped))
    else $error("pslverr does not follow address map");
  unmapped_zero_a: assert property (psel && !penable && !pwrite && unmapped |=> prdata == 32'h0)
    else $error("unmapped read not zero");
  prdata_hold_a: assert property (!(psel && !penable) |=> $stable(prdata))
    else $error("prdata changed outside setup");
  status_read_a: assert property (
    psel && !penable && !pwrite && paddr == dlc_pkg::ADDR_STATUS
    |=> prdata[7:0] == $past(dim_level) && prdata[17] == $past(night_mode))
    else $error("status read wrong");
  night_set_a: assert property (dn_valid && !dn_value && !sw_valid |=> night_mode)
    else $error("night mode not entered");
  day_set_a: assert property (dn_valid && dn_value && !sw_valid |=> !night_mode)
    else $error("day mode not entered");
  mode_hold_a: assert property (!(dn_valid && !sw_valid) |=> $stable(night_mode))
    else $error("mode changed without telegram");
  level_step_a: assert property (
    !tg && !$past(tg) |=> dim_level == $past(dim_level)
      || dim_level == $past(dim_level) + 8'h01 || dim_level == $past(dim_level) - 8'h01)
    else $error("level moved more than one step");
endmodule : dlc_top_asserts

bind dlc_top dlc_top_asserts u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .sw_valid(sw_valid), .dn_valid(dn_valid), .dn_value(dn_value), .rel_valid(rel_valid),
  .abs_valid(abs_valid), .rgb_valid(rgb_valid), .dim_level(dim_level),
  .night_mode(night_mode)
);
